// [src/cwd_pkg.sv]
// Operation
// - Word one at 2007h, two at 2008h, programming only
// - Bit 13 low: debugger owns programming pins
// - Bit 12 selects 500 kHz or 16 MHz
// - Unimplemented bits 11 and 7 read as one
// - Bit 10 selects 2.5 V or 1.9 V
// - Bits 9:8 set brown-out reset policy
// - Brown-out enable never enables power-up timer
// - Bit 6 low turns code protection on
// - Protection off erases the whole program memory
// - Bit 5 picks master clear or digital input
// - Master clear stops internal or RC oscillator
package cwd_pkg;

  // Word indices as printed; byte address is four times the index
  localparam logic [15:0] IDX_CFG1   = 16'h2007;
  localparam logic [15:0] IDX_CFG2   = 16'h2008;
  localparam logic [15:0] IDX_STATUS = 16'h2009;
  localparam logic [15:0] ADDR_CFG1   = 16'(IDX_CFG1 * 4);
  localparam logic [15:0] ADDR_CFG2   = 16'(IDX_CFG2 * 4);
  localparam logic [15:0] ADDR_STATUS = 16'(IDX_STATUS * 4);

  // Configuration word layout
  localparam int CFG_W        = 14;
  localparam int BIT_DEBUG_N  = 13;
  localparam int BIT_MULT_ON  = 12;
  localparam int BIT_UNIMP_HI = 11;
  localparam int BIT_THRESH   = 10;
  localparam int BIT_POL_HI   = 9;
  localparam int BIT_POL_LO   = 8;
  localparam int BIT_UNIMP_LO = 7;
  localparam int BIT_CODE_N   = 6;
  localparam int BIT_PIN_SEL  = 5;
  localparam int BIT_PWRT_N   = 4;
  localparam int BIT_WDT      = 3;
  localparam int BIT_OSC_HI   = 2;
  localparam int BIT_OSC_LO   = 0;

  // Erased words read all ones; unimplemented bits are forced high
  localparam logic [CFG_W-1:0] CFG1_RESET   = 14'h3fff;
  localparam logic [CFG_W-1:0] CFG2_RESET   = 14'h3fff;
  localparam logic [CFG_W-1:0] CFG1_ONES    = 14'h0880;

  // Brown-out policy codes
  localparam logic [1:0] POL_RUN_ONLY = 2'h2;
  localparam logic [1:0] POL_ALWAYS   = 2'h3;

  // Decoded figures
  localparam logic [15:0] FREQ_BASE_KHZ = 16'h01f4;
  localparam logic [15:0] FREQ_MULT_KHZ = 16'h3e80;
  localparam logic [15:0] THRESH_HI_MV  = 16'h09c4;
  localparam logic [15:0] THRESH_LO_MV  = 16'h076c;

  // Oscillator codes counted as internal or RC (neutral default)
  localparam logic [7:0] OSC_INT_RC_MASK = 8'hf0;

  // Status register bits
  localparam int ST_LOADED  = 0;
  localparam int ST_PROG    = 1;
  localparam int ST_ERASING = 2;

  // Erase sequencer
  typedef enum logic [0:0] {
    ER_IDLE = 1'b0,
    ER_BUSY = 1'b1
  } cwd_erase_t;

  // Decoded static controls
  typedef struct packed {
    logic        debuggerOwnsPins;
    logic        internalOscMultiplierOn;
    logic [15:0] internalOscFreqKhz;
    logic        brownoutThresholdSel;
    logic [15:0] brownoutThresholdMv;
    logic [1:0]  brownoutPolicy;
    logic        codeProtectN;
    logic        resetPinFunctionSel;
    logic        powerupTimerEnableN;
    logic        watchdogEnableCfg;
    logic [2:0]  oscillatorSelect;
  } cwd_ctrl_t;

endpackage

// [src/cwd_sync.sv]
// Two-flop synchroniser, one stage pair per bit
module cwd_sync #(
  parameter int WIDTH = 1                      // Number of bits
) (
  input  wire logic             core_clk,      // Core clock
  input  wire logic             nrst,          // Async reset, active low
  input  wire logic [WIDTH-1:0] asyncIn,       // Asynchronous inputs
  input  wire logic [WIDTH-1:0] resetVal,      // Unused tie, kept constant
  output logic      [WIDTH-1:0] syncOut        // Synchronised outputs
);

  genvar i;

  // Each bit gets its own stage pair; only the second stage is read
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;                              // First stage, read only below

      // Reset to zero; a constant as required under async reset
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          meta       <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta       <= asyncIn[i];
          syncOut[i] <= meta;
        end
      end
    end
  endgenerate

endmodule // cwd_sync

// [src/cwd_top.sv]
// Configuration word decode with APB access for the programmer
module cwd_top #(
  parameter logic [7:0] OSC_INT_RC_MASK = cwd_pkg::OSC_INT_RC_MASK  // Internal/RC osc codes
) (
  input  wire logic              core_clk,             // Core clock, 250 MHz
  input  wire logic              nrst,                 // Async reset, active low
  input  wire logic              psel,                 // APB select
  input  wire logic              penable,              // APB enable
  input  wire logic              pwrite,               // APB direction
  input  wire logic [15:0]       paddr,                // APB byte address
  input  wire logic [31:0]       pwdata,               // APB write data
  output logic      [31:0]       prdata,               // APB read data
  output logic                   pready,               // APB ready
  output logic                   pslverr,              // APB error
  input  wire logic              progModePin,          // Programming mode pin
  input  wire logic              portEBit3Pin,         // Shared reset pin
  input  wire logic              sleepMode,            // Core is in Sleep
  input  wire logic              eraseDone,            // Flash erase finished
  output cwd_pkg::cwd_ctrl_t     ctrl,                 // Decoded static controls
  output logic                   masterClearInputN,    // Internal master clear
  output logic                   portEBit3Data,        // Pin as digital input
  output logic                   internalOscillatorStop, // Stop internal osc
  output logic                   brownoutResetEnable,  // Brown-out reset armed
  output logic                   eraseReq              // Erase program memory
);

  // Synchronised pin levels
  logic                        progSync;              // Programming mode
  logic                        padSync;               // Reset pin level
  logic                        progPrev;              // For exit detection

  // Stored words, as seen by the programmer
  logic [cwd_pkg::CFG_W-1:0]   cfgOne;                // Word one storage
  logic [cwd_pkg::CFG_W-1:0]   cfgTwo;                // Word two storage
  logic                        loadPending;           // Decode owed

  // Erase sequencer
  cwd_pkg::cwd_erase_t         eraseState;            // Current state
  cwd_pkg::cwd_erase_t         next_eraseState;       // Next state

  // Bus decode
  logic                        setupPhase;            // Setup cycle of a transfer
  logic                        accessDone;            // Access completes this edge
  logic                        hitOne;                // Word one addressed
  logic                        hitTwo;                // Word two addressed
  logic                        hitStatus;             // Status addressed
  logic                        cfgHit;                // Either config word
  logic                        refuse;                // Access to be refused
  logic [cwd_pkg::CFG_W-1:0]   wrOne;                 // Word one as written
  logic                        startErase;            // Protection turned off
  logic                        progExit;              // Programming mode left
  logic                        loadNow;               // Decode this cycle
  logic [31:0]                 next_prdata;           // Read data for access

  // Both pins come from outside the clock domain
  cwd_sync #(
    .WIDTH    (2)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  ({progModePin, portEBit3Pin}),
    .resetVal (2'h0),
    .syncOut  ({progSync, padSync})
  );

  // Address decode on byte addresses of the printed word indices
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign hitOne     = (paddr == cwd_pkg::ADDR_CFG1);
  assign hitTwo     = (paddr == cwd_pkg::ADDR_CFG2);
  assign hitStatus  = (paddr == cwd_pkg::ADDR_STATUS);
  assign cfgHit     = hitOne || hitTwo;

  // Config words exist only in programming mode; status is read-only
  always_comb begin
    refuse = 1'b0;
    if (cfgHit && !progSync) begin
      refuse = 1'b1;
    end else if (cfgHit && pwrite && (eraseState == cwd_pkg::ER_BUSY)) begin
      refuse = 1'b1;
    end else if (hitStatus && pwrite) begin
      refuse = 1'b1;
    end else if (!cfgHit && !hitStatus) begin
      refuse = 1'b1;
    end
  end

  // Unimplemented bits cannot be programmed low
  assign wrOne = pwdata[cwd_pkg::CFG_W-1:0] | cwd_pkg::CFG1_ONES;

  // Protection going from on to off triggers a full erase
  assign startErase = accessDone && !pslverr && pwrite && hitOne
                    && !cfgOne[cwd_pkg::BIT_CODE_N]
                    && pwdata[cwd_pkg::BIT_CODE_N];

  // Decode follows reset and the end of each programming session
  assign progExit = progPrev && !progSync;
  assign loadNow  = (loadPending || progExit) && !progSync;

  // Read mux; evaluated during setup and registered for the access
  always_comb begin
    next_prdata = 32'h0;
    if (hitOne) begin
      next_prdata[cwd_pkg::CFG_W-1:0] = cfgOne | cwd_pkg::CFG1_ONES;
    end else if (hitTwo) begin
      next_prdata[cwd_pkg::CFG_W-1:0] = cfgTwo;
    end else if (hitStatus) begin
      next_prdata[cwd_pkg::ST_LOADED]  = !loadPending;
      next_prdata[cwd_pkg::ST_PROG]    = progSync;
      next_prdata[cwd_pkg::ST_ERASING] = (eraseState == cwd_pkg::ER_BUSY);
    end
  end

  // Zero-wait slave: ready, data and error stand in the access cycle only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && refuse;
      // Refused or write accesses return zero
      prdata  <= (setupPhase && !refuse && !pwrite) ? next_prdata : 32'h0;
    end
  end

  // Word storage; a real part keeps these in flash across resets
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfgOne <= cwd_pkg::CFG1_RESET;
      cfgTwo <= cwd_pkg::CFG2_RESET;
    end else if (accessDone && !pslverr && pwrite) begin
      // Writes land only at the completing access edge
      if (hitOne) begin
        cfgOne <= wrOne;
      end else if (hitTwo) begin
        cfgTwo <= pwdata[cwd_pkg::CFG_W-1:0];
      end
    end
  end

  // Remember the previous mode to see the session end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      progPrev <= 1'b0;
    end else begin
      progPrev <= progSync;
    end
  end

  // Decode owed from reset until the first cycle outside programming mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      loadPending <= 1'b1;
    end else if (progSync) begin
      // Entry invalidates the held copy until the session ends
      loadPending <= 1'b1;
    end else if (loadNow) begin
      loadPending <= 1'b0;
    end
  end

  // Erase sequencer next state; request holds until flash reports done
  always_comb begin
    next_eraseState = eraseState;
    unique case (eraseState)
      cwd_pkg::ER_IDLE: begin
        if (startErase) begin
          next_eraseState = cwd_pkg::ER_BUSY;
        end
      end
      cwd_pkg::ER_BUSY: begin
        if (eraseDone) begin
          next_eraseState = cwd_pkg::ER_IDLE;
        end
      end
    endcase
  end

  // Erase state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eraseState <= cwd_pkg::ER_IDLE;
    end else begin
      eraseState <= next_eraseState;
    end
  end

  // Erase request straight from a flop, high for the whole erase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eraseReq <= 1'b0;
    end else begin
      eraseReq <= (next_eraseState == cwd_pkg::ER_BUSY);
    end
  end

  // Decoded controls; held constant between loads so the clock,
  // reset and debug logic never see a half-programmed word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '0;
    end else if (loadNow) begin
      // Debugger takes the programming pins when the bit is low
      ctrl.debuggerOwnsPins        <= !cfgOne[cwd_pkg::BIT_DEBUG_N];
      // Multiplier on gives the fast internal frequency
      ctrl.internalOscMultiplierOn <= cfgOne[cwd_pkg::BIT_MULT_ON];
      ctrl.internalOscFreqKhz      <= cfgOne[cwd_pkg::BIT_MULT_ON]
                                    ? cwd_pkg::FREQ_MULT_KHZ
                                    : cwd_pkg::FREQ_BASE_KHZ;
      // Threshold select: low bit picks the higher trip level
      ctrl.brownoutThresholdSel    <= cfgOne[cwd_pkg::BIT_THRESH];
      ctrl.brownoutThresholdMv     <= cfgOne[cwd_pkg::BIT_THRESH]
                                    ? cwd_pkg::THRESH_LO_MV
                                    : cwd_pkg::THRESH_HI_MV;
      ctrl.brownoutPolicy          <= cfgOne[cwd_pkg::BIT_POL_HI:cwd_pkg::BIT_POL_LO];
      ctrl.codeProtectN            <= cfgOne[cwd_pkg::BIT_CODE_N];
      ctrl.resetPinFunctionSel     <= cfgOne[cwd_pkg::BIT_PIN_SEL];
      // Timer enable comes from its own bit only, never from policy
      ctrl.powerupTimerEnableN     <= cfgOne[cwd_pkg::BIT_PWRT_N];
      ctrl.watchdogEnableCfg       <= cfgOne[cwd_pkg::BIT_WDT];
      ctrl.oscillatorSelect        <= cfgOne[cwd_pkg::BIT_OSC_HI:cwd_pkg::BIT_OSC_LO];
    end
  end

  // Brown-out arming; the run-only code drops it in Sleep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      brownoutResetEnable <= 1'b0;
    end else begin
      unique case (ctrl.brownoutPolicy)
        cwd_pkg::POL_ALWAYS:   brownoutResetEnable <= 1'b1;
        cwd_pkg::POL_RUN_ONLY: brownoutResetEnable <= !sleepMode;
        default:               brownoutResetEnable <= 1'b0;
      endcase
    end
  end

  // Shared reset pin: master clear or plain digital input
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      masterClearInputN <= 1'b1;
      portEBit3Data     <= 1'b0;
    end else if (ctrl.resetPinFunctionSel) begin
      masterClearInputN <= padSync;
      portEBit3Data     <= 1'b0;
    end else begin
      // Internal clear is held inactive while the pin is an input
      masterClearInputN <= 1'b1;
      portEBit3Data     <= padSync;
    end
  end

  // Oscillator stop while clear is held in internal or RC mode;
  // external crystal modes keep running so they restart quickly
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      internalOscillatorStop <= 1'b0;
    end else begin
      internalOscillatorStop <= ctrl.resetPinFunctionSel && !padSync
                              && OSC_INT_RC_MASK[ctrl.oscillatorSelect];
    end
  end

endmodule // cwd_top

// [testbench/cwd_props.sv]
// Port-level checker for the configuration decode block
module cwd_props (
  input wire logic               core_clk,               // Clock
  input wire logic               nrst,                   // Reset, active low
  input wire logic               psel,                   // APB select
  input wire logic               penable,                // APB enable
  input wire logic               pwrite,                 // APB direction
  input wire logic [15:0]        paddr,                  // APB address
  input wire logic [31:0]        prdata,                 // APB read data
  input wire logic               pready,                 // APB ready
  input wire logic               pslverr,                // APB error
  input wire logic               progModePin,            // Programming mode
  input wire logic               eraseDone,              // Erase finished
  input wire cwd_pkg::cwd_ctrl_t ctrl,                   // Decoded controls
  input wire logic               masterClearInputN,      // Master clear
  input wire logic               internalOscillatorStop, // Oscillator stop
  input wire logic               brownoutResetEnable,    // Brown-out armed
  input wire logic               eraseReq                // Erase request
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic setup;  // Setup cycle of a transfer
  logic cfgAdr; // Address of a configuration word
  assign setup  = psel && !penable;
  assign cfgAdr = paddr == cwd_pkg::ADDR_CFG1 || paddr == cwd_pkg::ADDR_CFG2;

  // Bus answers exactly one cycle after setup, and only for one cycle
  chk_ready_after_setup: assert property (setup |=> pready)
    else $error("ready missing after setup");
  chk_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // Unmapped places and words outside a programming session are refused
  chk_unmapped_refused: assert property (setup && !cfgAdr && paddr != cwd_pkg::ADDR_STATUS
    |=> pslverr)
    else $error("unmapped access accepted");
  chk_cfg_needs_prog: assert property (setup && cfgAdr && !progModePin
    && $past(!progModePin) && $past(!progModePin, 2) |=> pslverr)
    else $error("word access outside programming accepted");
  // Unused bits come back high, upper bus bits low
  chk_unimp_ones: assert property (pready && !pslverr && !pwrite && paddr ==
    cwd_pkg::ADDR_CFG1 |-> prdata[31:14] == 18'h0 && prdata[11] && prdata[7])
    else $error("unused word bits not high");
  // Policy outputs lag the decoded field by one edge
  chk_bor_always: assert property ($past(ctrl.brownoutPolicy) == 2'h3 |-> brownoutResetEnable)
    else $error("brown-out not armed for policy 11");
  chk_bor_off: assert property (!$past(ctrl.brownoutPolicy[1]) |-> !brownoutResetEnable)
    else $error("brown-out armed for policy 0x");
  chk_master_clear_input_n_tied: assert property (!$past(ctrl.resetPinFunctionSel) |-> masterClearInputN)
    else $error("master clear active while pin is digital");
  chk_stop_needs_sel: assert property (!$past(ctrl.resetPinFunctionSel)
    |-> !internalOscillatorStop)
    else $error("oscillator stopped without master clear function");
  chk_stop_in_clear: assert property (internalOscillatorStop |-> !masterClearInputN)
    else $error("oscillator stopped while clear inactive");
  // Erase request holds until the flash reports done
  chk_erase_holds: assert property (eraseReq && !eraseDone |=> eraseReq)
    else $error("erase request dropped early");
  // A write during a session never moves the live controls
  chk_ctrl_held: assert property (psel && penable && pready && pwrite && !pslverr
    && progModePin && $past(progModePin) |=> $stable(ctrl))
    else $error("controls changed by a session write");
endmodule // cwd_props

bind cwd_top cwd_props chk (.*);

// [testbench/cwd_programmer.sv]
// Programmer model: runs APB cycles and answers erase like the flash does
module cwd_programmer #(
  parameter int ERASE_CYC = 20  // Erase length; long enough to try a write meanwhile
) (
  input  wire logic        core_clk,  // Clock
  input  wire logic        nrst,      // Reset, active low
  output logic             psel,      // APB select
  output logic             penable,   // APB enable
  output logic             pwrite,    // APB direction
  output logic [15:0]      paddr,     // APB address
  output logic [31:0]      pwdata,    // APB write data
  input  wire logic [31:0] prdata,    // APB read data
  input  wire logic        pready,    // APB ready
  input  wire logic        pslverr,   // APB error
  input  wire logic        eraseReq,  // Erase request
  output logic             eraseDone  // Erase finished
);
  timeunit 1ns;
  timeprecision 100ps;
  int   eraseCnt; // Cycles spent erasing
  logic timedOut; // Last transfer got no answer
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    timedOut = 1'b0;
  end

  // Flash answer: done rises after ERASE_CYC cycles, falls once request goes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eraseCnt  <= 0;
      eraseDone <= 1'b0;
    end else begin
      eraseCnt  <= eraseReq ? eraseCnt + 1 : 0;
      eraseDone <= eraseReq && eraseCnt >= ERASE_CYC;
    end
  end

  // One transfer; request held until ready is taken at a rising edge
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Read right after the edge: these are the values that edge sampled,
    // so ready, data and error are taken at the completing edge itself
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    timedOut = (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule // cwd_programmer

// [testbench/test_configuration_word_decode.sv]
// Bench for the configuration decode block
module test_configuration_word_decode;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr; // Clock, reset, bus
  logic [15:0] paddr;                                            // Bus address
  logic [31:0] pwdata, prdata, q;                                // Bus data
  logic progModePin, portEBit3Pin, sleepMode, eraseDone, err;    // Pins and status
  logic masterClearInputN, portEBit3Data, internalOscillatorStop; // Decoded pins
  logic brownoutResetEnable, eraseReq, pin, slp, bor, stp;       // Outputs, row fields
  logic [13:0] w;                                                // Row word
  cwd_pkg::cwd_ctrl_t ctrl;                                      // Decoded controls
  int bad_count, check_count, n;                                 // Counters
  // Rows: word, pin, sleep, expected brown-out, expected oscillator stop
  logic [17:0] rows [6] = '{18'h3fff3, 18'h1e4cc, 18'h2a653, 18'h01708, 18'h3c634, 18'h03476};

  cwd_top uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .progModePin(progModePin), .portEBit3Pin(portEBit3Pin),
    .sleepMode(sleepMode), .eraseDone(eraseDone), .ctrl(ctrl),
    .masterClearInputN(masterClearInputN), .portEBit3Data(portEBit3Data),
    .internalOscillatorStop(internalOscillatorStop),
    .brownoutResetEnable(brownoutResetEnable), .eraseReq(eraseReq));
  cwd_programmer host (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eraseReq(eraseReq), .eraseDone(eraseDone));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Expected controls worked out from the word layout
  function automatic cwd_pkg::cwd_ctrl_t expCtrl(input logic [13:0] x);
    return '{!x[13], x[12], x[12] ? 16'h3e80 : 16'h01f4, x[10], x[10] ? 16'h076c : 16'h09c4,
             x[9:8], x[6], x[5], x[4], x[3], x[2:0]};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One bus transfer with answer compared; a hang ends the run
  task automatic rw(input logic wr, input logic [15:0] a, input logic [31:0] d,
                    input logic [31:0] expQ, input logic expErr);
    host.xfer(wr, a, d, q, err);
    if (host.timedOut) begin
      bad_count++;
      test_done();
    end
    chk(err, expErr);
    if (!wr) chk(q, expQ);
  endtask

  // Session on or off, then settle past the pin synchronisers
  task automatic session(input logic on);
    @(posedge core_clk);
    progModePin <= on;
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  initial begin
    {nrst, progModePin, portEBit3Pin, sleepMode} = 4'h0;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    session(1'b0);
    chk(ctrl, expCtrl(14'h3fff));
    // Row loop: program a word, close the session, look at the decode
    foreach (rows[i]) begin
      {w, pin, slp, bor, stp} = rows[i];
      session(1'b1);
      rw(1'b1, cwd_pkg::ADDR_CFG1, {18'h0, w}, 32'h0, 1'b0);
      rw(1'b0, cwd_pkg::ADDR_CFG1, 32'h0, {18'h0, w | 14'h0880}, 1'b0);
      chk(ctrl, expCtrl((i == 0) ? 14'h3fff : rows[i - 1][17:4]));
      portEBit3Pin <= pin;
      sleepMode    <= slp;
      session(1'b0);
      chk(ctrl, expCtrl(w));
      chk(brownoutResetEnable, bor);
      chk(internalOscillatorStop, stp);
      chk(masterClearInputN, w[5] ? pin : 1'b1);
      chk(portEBit3Data, w[5] ? 1'b0 : pin);
      $display("row %0d done", i);
    end
    // Refusals outside a session, unmapped place, read-only status
    rw(1'b0, cwd_pkg::ADDR_CFG1, 32'h0, 32'h0, 1'b1);
    rw(1'b0, 16'h0000, 32'h0, 32'h0, 1'b1);
    rw(1'b1, cwd_pkg::ADDR_STATUS, 32'h7, 32'h0, 1'b1);
    rw(1'b0, cwd_pkg::ADDR_STATUS, 32'h0, 32'h1, 1'b0);
    $display("refusal test done");
    // Protect on, then off: erase runs and blocks writes meanwhile
    session(1'b1);
    rw(1'b0, cwd_pkg::ADDR_CFG2, 32'h0, 32'h3fff, 1'b0);
    rw(1'b1, cwd_pkg::ADDR_CFG1, 32'h3fbf, 32'h0, 1'b0);
    session(1'b0);
    chk(ctrl, expCtrl(14'h3fbf));
    session(1'b1);
    rw(1'b1, cwd_pkg::ADDR_CFG1, 32'h3fff, 32'h0, 1'b0);
    @(posedge core_clk);
    #1;
    chk(eraseReq, 1'b1);
    rw(1'b0, cwd_pkg::ADDR_STATUS, 32'h0, 32'h6, 1'b0);
    rw(1'b1, cwd_pkg::ADDR_CFG1, 32'h3fbf, 32'h0, 1'b1);
    n = 0;
    while (eraseReq !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) begin
      bad_count++;
      test_done();
    end
    rw(1'b1, cwd_pkg::ADDR_CFG1, 32'h1e4c, 32'h0, 1'b0);
    session(1'b0);
    chk(ctrl, expCtrl(14'h1e4c));
    $display("erase test done");
    // Reset in mid-run reloads the erased word
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(ctrl, 64'h0);
    chk(masterClearInputN, 1'b1);
    nrst <= 1'b1;
    session(1'b0);
    chk(ctrl, expCtrl(14'h3fff));
    $display("reset test done");
    test_done();
  end
endmodule // test_configuration_word_decode
